// ---- src/cms_strap_decode.sv ----
// Purpose: Control mode, strap and scan pin decode with aux clock gating
// Assumes: Three-level mode pin arrives as separate low and mid threshold comparators
// Notes: Aux clock divides core_clk by 2*(rate+1)
// Notes: Strap roles follow the raw mode decode, in step with mode
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module cms_strap_decode #(
    parameter bit E1_DEFAULT_120 = 1'b0 // Set for the 120 ohm variant
) (
    input wire logic core_clk, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic mode_above_low, // Mode pin above low threshold
    input wire logic mode_above_mid, // Mode pin above mid threshold
    input wire logic mux_imp_pin, // Multiplex select / line_impedance_select
    input wire logic style_code_pin, // bus_style_select / line code select
    input wire logic e1_mode, // Line operates in E1
    input wire logic j1_mode, // Line operates in J1 (T1 family)
    input wire logic scan_mode_pin, // Scan mode select, pulled low
    input wire logic los8_scan_en_in, // loss_of_signal_out_ch8 pad input
    input wire logic los8_value, // Loss flag to show on the shared pin
    input wire logic [cms_pkg::ADDR_W-1:0] reg_addr, // Register address
    input wire logic [cms_pkg::DATA_W-1:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [cms_pkg::DATA_W-1:0] reg_rdata, // Read data, cycle after strobe
    output cms_pkg::cms_mode_t mode, // Decoded control mode
    output logic bus_muxed, // Parallel bus multiplexed
    output logic bus_rw_strobes, // Separate read and write strobes
    output cms_pkg::cms_imp_t impedance, // Hardware mode impedance
    output cms_pkg::cms_code_t line_code, // Hardware mode line code
    output logic scan_active, // Scan test mode
    output logic scan_shift_en, // Scan shift enable
    output logic los8_out, // Shared pin drive value
    output logic los8_oe_n, // Shared pin enable, low drives
    output logic aux_clock_out, // Programmable clock value
    output logic aux_clock_oe_n // Aux pin enable, low drives
);
    import cms_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: stage one is read by stage two only
    // Straps are levels, so two flops only guard against metastability
    logic [5:0] sync1_q;
    logic [5:0] sync2_q;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            sync1_q <= 6'h00;
        else
            sync1_q <= {los8_scan_en_in, scan_mode_pin, style_code_pin, mux_imp_pin,
                        mode_above_mid, mode_above_low};
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            sync2_q <= 6'h00;
        else
            sync2_q <= sync1_q;
    end

    logic s_low;
    logic s_mid;
    logic s_mux;
    logic s_style;
    logic s_scan;
    logic s_scan_en;
    assign s_low = sync2_q[0];
    assign s_mid = sync2_q[1];
    assign s_mux = sync2_q[2];
    assign s_style = sync2_q[3];
    assign s_scan = sync2_q[4];
    assign s_scan_en = sync2_q[5];

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode
    cms_mode_t mode_d;
    always_comb
    begin
        case ({s_mid, s_low})
            2'b00: mode_d = CMS_MODE_HW;
            2'b01: mode_d = CMS_MODE_SERIAL;
            2'b11: mode_d = CMS_MODE_PARALLEL;
            default: mode_d = CMS_MODE_HW; // Inconsistent comparators: safest mode
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            mode <= CMS_MODE_HW;
        else
            mode <= mode_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Dual-function strap routing, unselected role held at zero
    function automatic cms_imp_t imp_decode(input logic sel, input logic e1,
                                            input logic j1, input logic swap);
        logic eff;
        eff = e1 ? (sel ^ swap) : sel;
        if (e1)
            imp_decode = eff ? CMS_IMP_120 : CMS_IMP_75;
        else
            imp_decode = sel ? (j1 ? CMS_IMP_110 : CMS_IMP_120) : CMS_IMP_100;
    endfunction

    // Host-only features: register writes and the aux clock
    function automatic logic host_mode(input cms_mode_t m);
        host_mode = m != CMS_MODE_HW;
    endfunction

    // Each strap role in its own flop; the unselected role reads as zero
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            bus_muxed <= 1'b0;
        else
        begin
            case (mode_d)
                CMS_MODE_PARALLEL: bus_muxed <= s_mux;
                default: bus_muxed <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            bus_rw_strobes <= 1'b0;
        else
        begin
            case (mode_d)
                CMS_MODE_PARALLEL: bus_rw_strobes <= s_style;
                default: bus_rw_strobes <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            impedance <= CMS_IMP_75;
        else
        begin
            case (mode_d)
                CMS_MODE_HW: impedance <= imp_decode(s_mux, e1_mode, j1_mode,
                                                     E1_DEFAULT_120);
                default: impedance <= CMS_IMP_75;
            endcase
        end
    end

    // E1 picks HDB3 as the zero-suppression code; J1 and T1 both take B8ZS
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            line_code <= CMS_CODE_AMI;
        else
        begin
            case (mode_d)
                CMS_MODE_HW:
                begin
                    if (s_style)
                        line_code <= CMS_CODE_AMI;
                    else if (e1_mode)
                        line_code <= CMS_CODE_HDB3;
                    else
                        line_code <= CMS_CODE_B8ZS;
                end
                default: line_code <= CMS_CODE_AMI;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Scan test and the shared loss-of-signal pin
    // Scan pin changes reach scan_active, scan_shift_en and los8_oe_n in the same cycle
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            scan_active <= 1'b0;
        else
            scan_active <= s_scan;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            scan_shift_en <= 1'b0;
        else
            scan_shift_en <= s_scan & s_scan_en;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            los8_out <= 1'b0;
        else
            los8_out <= los8_value;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            los8_oe_n <= 1'b1;
        else
            los8_oe_n <= s_scan;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] mc_q;
    logic [7:0] ccr_q;
    logic aux_en;
    logic [7:0] status_word;
    assign aux_en = mc_q[MC_AUX_EN_BIT] && host_mode(mode);
    // Status view of what the pins decoded to
    assign status_word = {2'h0, line_code, scan_active, aux_en, mode};

    // Writes only land in host modes; reads work in every mode
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mc_q <= MC_RESET;
            ccr_q <= CCR_RESET;
        end
        else if (reg_wr && host_mode(mode))
        begin
            if (reg_addr == MASTER_CONFIG_OFS)
                mc_q <= reg_wdata;
            if (reg_addr == CLOCK_RATE_CONFIG_OFS)
                ccr_q <= reg_wdata & CCR_MASK;
        end
    end

    // Read data stands one cycle, zero otherwise
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= UNMAPPED_READ;
        else if (reg_rd)
        begin
            case (reg_addr)
                MASTER_CONFIG_OFS: reg_rdata <= mc_q;
                CLOCK_RATE_CONFIG_OFS: reg_rdata <= ccr_q;
                STATUS_OFS: reg_rdata <= status_word;
                default: reg_rdata <= UNMAPPED_READ;
            endcase
        end
        else
            reg_rdata <= UNMAPPED_READ;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Aux clock divider; stops and floats whenever disabled
    // Stopping low makes the first edge after enable a clean rise
    // Half period is rate + 1 clocks
    logic [7:0] div_q;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            div_q <= 8'h00;
        else if (!aux_en || div_q >= ccr_q)
            div_q <= 8'h00;
        else
            div_q <= div_q + 8'h01;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            aux_clock_out <= 1'b0;
        else if (!aux_en)
            aux_clock_out <= 1'b0;
        else if (div_q >= ccr_q)
            aux_clock_out <= ~aux_clock_out;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            aux_clock_oe_n <= 1'b1;
        else
            aux_clock_oe_n <= !aux_en;
    end
endmodule

// ---- src/cms_pkg.sv ----
// Purpose: Shared constants for the control mode and strap decoder
// Assumes: Strap pins already resolved to digital levels outside this block
// Notes: Register offsets apply to the plain register port only
package cms_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [3:0] MASTER_CONFIG_OFS = 4'h0;
    localparam logic [3:0] CLOCK_RATE_CONFIG_OFS = 4'h1;
    localparam logic [3:0] STATUS_OFS = 4'h2;
    localparam int MC_AUX_EN_BIT = 0;
    localparam logic [7:0] MC_RESET = 8'h00;
    localparam logic [7:0] CCR_RESET = 8'h00;
    localparam logic [7:0] CCR_MASK = 8'h07;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    typedef enum logic [1:0] {
        CMS_MODE_HW = 2'b00,
        CMS_MODE_SERIAL = 2'b01,
        CMS_MODE_PARALLEL = 2'b10
    } cms_mode_t;

    typedef enum logic [1:0] {
        CMS_IMP_75 = 2'b00,
        CMS_IMP_100 = 2'b01,
        CMS_IMP_110 = 2'b10,
        CMS_IMP_120 = 2'b11
    } cms_imp_t;

    typedef enum logic [1:0] {
        CMS_CODE_AMI = 2'b00,
        CMS_CODE_B8ZS = 2'b01,
        CMS_CODE_HDB3 = 2'b10
    } cms_code_t;
endpackage

// ---- tb/cms_strap_board.sv ----
// Purpose: Board strap model for the three-level mode pin
// Assumes: Level 0 low, 1 mid-supply, 2 high
// Notes: Levels only change while the bus is idle
`timescale 1ns/10ps
module cms_strap_board (
    input wire logic [1:0] level, // Strap level
    output logic mode_above_low, // Low threshold comparator
    output logic mode_above_mid // Mid threshold comparator
);
    assign mode_above_low = level != 2'h0;
    assign mode_above_mid = level == 2'h2;
endmodule

// ---- tb/cms_strap_decode_assertions.sv ----
// Purpose: Port checks for the strap decoder
// Assumes: Pins held several cycles around each change
// Notes: Bound to every decoder instance
`timescale 1ns/10ps
module cms_strap_decode_chk
    import cms_pkg::*;
(
    input wire logic core_clk, // Clock
    input wire logic rst_n, // Reset
    input wire logic scan_mode_pin, // Scan select
    input wire logic los8_scan_en_in, // Shared pin input
    input wire logic reg_rd, // Read strobe
    input wire logic [DATA_W-1:0] reg_rdata, // Read data
    input wire cms_mode_t mode, // Mode
    input wire logic bus_muxed, // Muxed bus
    input wire logic bus_rw_strobes, // Strobe style
    input wire cms_imp_t impedance, // Impedance
    input wire cms_code_t line_code, // Line code
    input wire logic scan_active, // Scan on
    input wire logic scan_shift_en, // Shift enable
    input wire logic los8_oe_n, // Shared pin enable
    input wire logic aux_clock_oe_n // Aux enable
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
////////////////////////////////////////////////////////////////////////////////
    mode_legal_a: assert property (mode != 2'b11) else $error("bad mode");
    bus_role_a: assert property (mode != CMS_MODE_PARALLEL
        |-> !bus_muxed && !bus_rw_strobes) else $error("bus select outside parallel");
    strap_role_a: assert property (mode != CMS_MODE_HW |-> impedance == CMS_IMP_75
        && line_code == CMS_CODE_AMI) else $error("strap outside hardware");
    aux_hw_a: assert property (mode == CMS_MODE_HW && $past(mode) == CMS_MODE_HW
        |-> aux_clock_oe_n) else $error("aux driven in hardware");
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray rdata");
    scan_release_a: assert property (scan_active && $past(scan_active) |-> los8_oe_n)
        else $error("shared pin driven in scan");
    shift_off_a: assert property (!scan_active && !$past(scan_active) |-> !scan_shift_en)
        else $error("shift outside scan");
    scan_sync_a: assert property ($stable(scan_mode_pin)[*4] |-> scan_active == scan_mode_pin)
        else $error("scan mode lag");
    shift_sync_a: assert property ((scan_mode_pin && $stable(los8_scan_en_in))[*4]
        |-> scan_shift_en == los8_scan_en_in) else $error("shift lag");
    aux_c: cover property (mode == CMS_MODE_PARALLEL && !aux_clock_oe_n);
    shift_c: cover property (scan_shift_en);
    rd_c: cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule
bind cms_strap_decode cms_strap_decode_chk chk_inst (.*);

// ---- tb/control_mode_strap_decode_tb.sv ----
// Purpose: Random and corner checks of the strap decoder
// Assumes: Default 75 ohm variant, plus a 120 ohm variant instance checked for impedance
// Notes: Pins held five cycles before outputs are compared
`timescale 1ns/10ps
module control_mode_strap_decode_tb;
    import cms_pkg::*;
    logic core_clk = 0, rst_n = 0, mux_imp_pin = 0, style_code_pin = 0, e1_mode = 0, j1_mode = 0;
    logic scan_mode_pin = 0, los8_scan_en_in = 0, los8_value = 0, reg_wr = 0, reg_rd = 0;
    logic mode_above_low, mode_above_mid, bus_muxed, bus_rw_strobes, scan_active, scan_shift_en;
    logic los8_out, los8_oe_n, aux_clock_out, aux_clock_oe_n;
    logic [1:0] level = 0;
    logic [3:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, reg_rdata, d, x;
    logic [31:0] s = 32'h000027f8, r;
    cms_mode_t mode;
    cms_imp_t impedance;
    cms_imp_t impedance_v120;
    cms_code_t line_code;
    int errors = 0, n_checks = 0, cyc = 0, n;
    cms_strap_board cms_strap_board_inst (.*);
    cms_strap_decode cms_strap_decode_inst (.*);
    cms_strap_decode #(.E1_DEFAULT_120(1'b1)) cms_strap_decode_v120_inst (
        .core_clk(core_clk), .rst_n(rst_n), .mode_above_low(mode_above_low),
        .mode_above_mid(mode_above_mid), .mux_imp_pin(mux_imp_pin),
        .style_code_pin(style_code_pin), .e1_mode(e1_mode), .j1_mode(j1_mode),
        .scan_mode_pin(scan_mode_pin), .los8_scan_en_in(los8_scan_en_in),
        .los8_value(los8_value), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(), .mode(), .bus_muxed(),
        .bus_rw_strobes(), .impedance(impedance_v120), .line_code(), .scan_active(),
        .scan_shift_en(), .los8_out(), .los8_oe_n(), .aux_clock_out(), .aux_clock_oe_n());
    initial
        forever #10 core_clk = ~core_clk;
////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    function automatic logic [7:0] expv(logic [1:0] l);
        logic hw;
        hw = l == 2'h0;
        return {style_code_pin & l[1], mux_imp_pin & l[1],
            2'(hw ? (style_code_pin ? 0 : e1_mode ? 2 : 1) : 0),
            2'(hw ? (!mux_imp_pin ? (e1_mode ? 0 : 1) : (e1_mode | !j1_mode) ? 3 : 2) : 0), l};
    endfunction
    task automatic chk(logic [9:0] g, logic [9:0] e);
        n_checks++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] v);
        @(posedge core_clk);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 0;
    endtask
    task automatic rd(logic [3:0] a);
        @(posedge core_clk);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask
    task automatic half(output int k);
        logic t;
        t = aux_clock_out;
        for (k = 0; k < 20 && aux_clock_out === t; k++)
            @(negedge core_clk);
    endtask
    task automatic settle();
        repeat (5) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            errors++;
            end_of_test();
        end
    end
////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1;
        for (int i = 0; i < 60; i++)
        begin
            @(posedge core_clk);
            r = xs();
            level <= (i < 3) ? 2'(i) : 2'(r % 3);
            {mux_imp_pin, style_code_pin, e1_mode, j1_mode, los8_value} <= r[8:4];
            settle();
            chk({los8_oe_n, los8_out, bus_rw_strobes, bus_muxed, line_code, impedance, mode},
                {1'b0, los8_value, expv(level)});
            x = expv(level);
            if (level == 2'h0 && e1_mode)
                x[3:2] = mux_imp_pin ? 2'h0 : 2'h3;
            chk(impedance_v120, x[3:2]);
        end
        @(posedge core_clk);
        level <= 2'h2;
        settle();
        for (int c = 0; c < 2; c++)
        begin
            r = xs() & 32'h7;
            wr(4'h0, 8'h01);
            wr(4'h1, r[7:0]);
            half(n);
            half(n);
            chk(n, r + 1);
            chk(aux_clock_oe_n, 0);
            rd(4'h2);
            chk(d, 8'h06);
            rd(4'hf);
            chk(d, 8'h00);
        end
        @(posedge core_clk);
        level <= 2'h0;
        settle();
        wr(4'h0, 8'h01);
        rd(4'h2);
        chk({aux_clock_oe_n, d[2]}, 2'b10);
        wr(4'h0, 8'h00);
        rd(4'h0);
        chk(d, 8'h01);
        for (int i = 0; i < 5; i++)
        begin
            @(posedge core_clk);
            scan_mode_pin <= i < 4;
            los8_scan_en_in <= xs() & 1;
            settle();
            chk({scan_active, scan_shift_en, los8_oe_n},
                {i < 4, los8_scan_en_in & (i < 4), i < 4});
        end
        end_of_test();
    end
endmodule
